// *** ppmi_pkg.sv ***
package ppmi_pkg;

  // register byte addresses
  localparam logic [7:0] PPMI_ADDR_MASK     = 8'h00;
  localparam logic [7:0] PPMI_ADDR_PATTERN  = 8'h04;
  localparam logic [7:0] PPMI_ADDR_CONTROL  = 8'h08;
  localparam logic [7:0] PPMI_ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] PPMI_ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] PPMI_ADDR_PORT     = 8'h14;
  localparam int         PPMI_ADDR_W        = 8;

  // key_match_control fields
  localparam int PPMI_CTL_ACTIVE_BIT = 0;
  localparam int PPMI_CTL_POL_BIT    = 1;
  localparam int PPMI_CTL_INTEN_BIT  = 2;
  localparam int PPMI_CTL_FLAG_BIT   = 3;

  // irq status / irq mask fields
  localparam int PPMI_IRQ_MATCH_BIT = 0;
  localparam int PPMI_IRQ_WAKE_BIT  = 1;
  localparam int PPMI_IRQ_W         = 2;

  // reset values
  localparam logic [7:0] PPMI_MASK_RST    = 8'h00;
  localparam logic [7:0] PPMI_PATTERN_RST = 8'h00;
  localparam logic [1:0] PPMI_IRQ_RST     = 2'h0;

  // match must persist longer than this many core clocks
  localparam int PPMI_MATCH_HOLD_CLKS = 6;
  localparam int PPMI_PORT_WIDTH      = 8;

endpackage

// *** ppmi_hold_filter.sv ***
`timescale 1ns/100ps
`default_nettype none

module ppmi_hold_filter #(
  parameter int HOLD = 6
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic cond,
  output logic      pass
);

  localparam int CW = $clog2(HOLD + 2);
  localparam logic [CW-1:0] CNT_MAX = CW'(HOLD);

  if (HOLD < 1) begin : g_chk
    $error("ppmi_hold_filter: HOLD must be at least 1");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          pass;
  } ppmi_filt_t;

  ppmi_filt_t st_q;
  ppmi_filt_t st_d;

  // counts consecutive cycles of cond; pass once cond has been seen HOLD+1 cycles
  always_comb begin
    st_d = st_q;
    if (!cond) begin
      st_d.cnt = '0;
    end else if (st_q.cnt < CNT_MAX) begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
    st_d.pass = cond && (st_q.cnt >= CNT_MAX);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pass = st_q.pass;

endmodule

`default_nettype wire

// *** ppmi_top.sv ***
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - mask bits choose which port pins take part; masked pins never affect matching.
// - stored pattern is compared continuously with the live port value.
// - polarity bit picks equal or not-equal as the match condition.
// - flag sets when the selected condition holds while the function is active.
// - interrupt request comes from the flag only when its enable is set.
// - pattern all ones with not-equal: any unmasked pin low sets the flag.
// - enabled match interrupt wakes the core from idle and power-down.
// - flag sets only after the condition persists more than six clocks.
module ppmi_top
#(
  parameter int PORT_WIDTH = ppmi_pkg::PPMI_PORT_WIDTH,
  parameter int HOLD_CLKS  = ppmi_pkg::PPMI_MATCH_HOLD_CLKS
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [31:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [PORT_WIDTH-1:0] port_in,
  input  wire logic                  idle_mode,
  input  wire logic                  power_down_mode,
  output logic                       key_int_req,
  output logic                       core_wake,
  output logic                       irq
);

  import ppmi_pkg::*;

  if (PORT_WIDTH < 1 || PORT_WIDTH > 8) begin : g_chk_width
    $error("ppmi_top: PORT_WIDTH must be 1 to 8");
  end
  if (HOLD_CLKS < 1) begin : g_chk_hold
    $error("ppmi_top: HOLD_CLKS must be at least 1");
  end

  typedef struct packed {
    logic [PORT_WIDTH-1:0] key_match_mask;
    logic [PORT_WIDTH-1:0] key_match_pattern;
    logic                  active;
    logic                  match_polarity_select;
    logic                  int_en;
    logic                  pattern_match_flag;
    logic [PPMI_IRQ_W-1:0] irq_status;
    logic [PPMI_IRQ_W-1:0] irq_mask;
    logic                  ack;
    logic [31:0]           rdata;
    logic                  int_req;
    logic                  wake;
    logic                  irq;
  } ppmi_state_t;

  ppmi_state_t st_q;
  ppmi_state_t st_d;

  logic [PORT_WIDTH-1:0] pin_differs;
  logic                  all_equal;
  logic                  match_cond;
  logic                  hold_pass;

  // per-pin compare, gated by the mask
  for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
    assign pin_differs[i] = st_q.key_match_mask[i] &&
                            (port_in[i] != st_q.key_match_pattern[i]);
  end

  assign all_equal  = (pin_differs == '0);
  // polarity 1 selects not-equal, so pattern all ones catches any pin pulled low
  assign match_cond = st_q.active &&
                      (st_q.match_polarity_select ? !all_equal : all_equal);

  ppmi_hold_filter #(
    .HOLD (HOLD_CLKS)
  ) u_hold (
    .clock   (clock),
    .sys_rst (sys_rst),
    .cond    (match_cond),
    .pass    (hold_pass)
  );

  logic                  bus_req;
  logic                  bus_wr;
  logic [PPMI_ADDR_W-1:0] bus_addr;
  logic                  addr_hi_zero;
  logic                  flag_set;
  logic                  flag_rise;
  logic                  sleeping;
  logic                  wake_cond;
  logic [PPMI_IRQ_W-1:0] irq_events;
  logic [31:0]           rd_word;

  assign bus_req      = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign bus_wr       = bus_req && wb_we_i && wb_sel_i[0];
  assign bus_addr     = wb_adr_i[PPMI_ADDR_W-1:0];
  assign addr_hi_zero = (wb_adr_i[31:PPMI_ADDR_W] == '0);

  assign flag_set  = hold_pass && st_q.active;
  assign flag_rise = flag_set && !st_q.pattern_match_flag;
  assign sleeping  = idle_mode || power_down_mode;
  assign wake_cond = sleeping && st_q.pattern_match_flag && st_q.int_en;

  always_comb begin
    irq_events = '0;
    irq_events[PPMI_IRQ_MATCH_BIT] = flag_rise;
    irq_events[PPMI_IRQ_WAKE_BIT]  = wake_cond && !st_q.wake;
  end

  // read mux; unmapped or out-of-range addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (addr_hi_zero) begin
      case (bus_addr)
        PPMI_ADDR_MASK: begin
          rd_word[PORT_WIDTH-1:0] = st_q.key_match_mask;
        end
        PPMI_ADDR_PATTERN: begin
          rd_word[PORT_WIDTH-1:0] = st_q.key_match_pattern;
        end
        PPMI_ADDR_CONTROL: begin
          rd_word[PPMI_CTL_ACTIVE_BIT] = st_q.active;
          rd_word[PPMI_CTL_POL_BIT]    = st_q.match_polarity_select;
          rd_word[PPMI_CTL_INTEN_BIT]  = st_q.int_en;
          rd_word[PPMI_CTL_FLAG_BIT]   = st_q.pattern_match_flag;
        end
        PPMI_ADDR_IRQ_STAT: begin
          rd_word[PPMI_IRQ_W-1:0] = st_q.irq_status;
        end
        PPMI_ADDR_IRQ_MASK: begin
          rd_word[PPMI_IRQ_W-1:0] = st_q.irq_mask;
        end
        PPMI_ADDR_PORT: begin
          rd_word[PORT_WIDTH-1:0] = port_in;
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  always_comb begin
    st_d       = st_q;
    st_d.ack   = bus_req;
    st_d.rdata = bus_req ? rd_word : st_q.rdata;

    if (bus_wr && addr_hi_zero) begin
      case (bus_addr)
        PPMI_ADDR_MASK: begin
          st_d.key_match_mask = wb_dat_i[PORT_WIDTH-1:0];
        end
        PPMI_ADDR_PATTERN: begin
          st_d.key_match_pattern = wb_dat_i[PORT_WIDTH-1:0];
        end
        PPMI_ADDR_CONTROL: begin
          st_d.active                = wb_dat_i[PPMI_CTL_ACTIVE_BIT];
          st_d.match_polarity_select = wb_dat_i[PPMI_CTL_POL_BIT];
          st_d.int_en                = wb_dat_i[PPMI_CTL_INTEN_BIT];
          // writing one leaves the flag alone; only zero clears it
          if (!wb_dat_i[PPMI_CTL_FLAG_BIT]) begin
            st_d.pattern_match_flag = 1'b0;
          end
        end
        PPMI_ADDR_IRQ_STAT: begin
          st_d.irq_status = st_q.irq_status & ~wb_dat_i[PPMI_IRQ_W-1:0];
        end
        PPMI_ADDR_IRQ_MASK: begin
          st_d.irq_mask = wb_dat_i[PPMI_IRQ_W-1:0];
        end
        default: begin
          st_d.active = st_q.active;
        end
      endcase
    end

    // hardware set wins over a same-cycle software clear
    if (flag_set) begin
      st_d.pattern_match_flag = 1'b1;
    end
    st_d.irq_status = st_d.irq_status | irq_events;

    st_d.int_req = st_d.pattern_match_flag && st_d.int_en;
    st_d.wake    = wake_cond;
    st_d.irq     = |(st_d.irq_status & st_d.irq_mask);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q                   <= '0;
      st_q.key_match_mask    <= PPMI_MASK_RST[PORT_WIDTH-1:0];
      st_q.key_match_pattern <= PPMI_PATTERN_RST[PORT_WIDTH-1:0];
      st_q.irq_status        <= PPMI_IRQ_RST;
      st_q.irq_mask          <= PPMI_IRQ_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o    = st_q.ack;
  assign wb_dat_o    = st_q.rdata;
  assign key_int_req = st_q.int_req;
  assign core_wake   = st_q.wake;
  assign irq         = st_q.irq;

  // checks

  a_ack_one_cycle:
  assert property (@(posedge clock) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
  else $error("ack held longer than one cycle");

  a_ack_answers_req:
  assert property (@(posedge clock) disable iff (sys_rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
  else $error("bus request not answered next cycle");

  a_masked_pins_out:
  assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.key_match_mask == '0) |-> all_equal)
  else $error("masked pins affected the compare");

  a_compare_live:
  assert property (@(posedge clock) disable iff (sys_rst)
    all_equal == (((port_in ^ st_q.key_match_pattern) & st_q.key_match_mask) == '0))
  else $error("pattern compare disagrees with port");

  a_polarity_pick:
  assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.active && st_q.match_polarity_select && all_equal) |-> !match_cond)
  else $error("not-equal mode matched an equal port");

  a_long_match_sets:
  assert property (@(posedge clock) disable iff (sys_rst)
    match_cond [*8] |=> st_q.pattern_match_flag)
  else $error("persistent match did not set the flag");

  a_short_ignored:
  assert property (@(posedge clock) disable iff (sys_rst)
    $rose(st_q.pattern_match_flag) |->
      $past(match_cond, 2) && $past(match_cond, 5) && $past(match_cond, 8))
  else $error("flag set without seven clocks of match");

  a_int_req_gated:
  assert property (@(posedge clock) disable iff (sys_rst)
    key_int_req |-> (st_q.pattern_match_flag && st_q.int_en))
  else $error("interrupt request without enabled flag");

  a_any_key_low:
  assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.active && st_q.match_polarity_select && (&st_q.key_match_pattern) &&
     ((~port_in & st_q.key_match_mask) != '0)) [*8] |=> st_q.pattern_match_flag)
  else $error("any-key press did not set the flag");

  a_wake_from_sleep:
  assert property (@(posedge clock) disable iff (sys_rst)
    core_wake |-> $past(sleeping && st_q.pattern_match_flag && st_q.int_en))
  else $error("wake without enabled flag while sleeping");

  a_flag_clear_zero:
  assert property (@(posedge clock) disable iff (sys_rst)
    (bus_wr && addr_hi_zero && bus_addr == PPMI_ADDR_CONTROL &&
     !wb_dat_i[PPMI_CTL_FLAG_BIT] && !flag_set) |=> !st_q.pattern_match_flag)
  else $error("flag not cleared by writing zero");

  a_irq_level:
  assert property (@(posedge clock) disable iff (sys_rst)
    irq == (|(st_q.irq_status & st_q.irq_mask)))
  else $error("irq does not follow masked status");

  a_inactive_quiet:
  assert property (@(posedge clock) disable iff (sys_rst)
    !st_q.active |=> !hold_pass)
  else $error("inactive block let the hold filter pass");

  a_flag_needs_on:
  assert property (@(posedge clock) disable iff (sys_rst)
    $rose(st_q.pattern_match_flag) |-> $past(st_q.active))
  else $error("flag set while the function was off");

  a_match_event:
  assert property (@(posedge clock) disable iff (sys_rst)
    $rose(st_q.pattern_match_flag) |-> st_q.irq_status[PPMI_IRQ_MATCH_BIT])
  else $error("flag rise did not log a match event");

  a_equal_mode:
  assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.active && !st_q.match_polarity_select) |-> (match_cond == all_equal))
  else $error("equal mode does not follow the compare");

  a_mask_write:
  assert property (@(posedge clock) disable iff (sys_rst)
    (bus_wr && addr_hi_zero && bus_addr == PPMI_ADDR_MASK) |=>
      (st_q.key_match_mask == $past(wb_dat_i[PORT_WIDTH-1:0])))
  else $error("mask write did not land");

  a_pattern_write:
  assert property (@(posedge clock) disable iff (sys_rst)
    (bus_wr && addr_hi_zero && bus_addr == PPMI_ADDR_PATTERN) |=>
      (st_q.key_match_pattern == $past(wb_dat_i[PORT_WIDTH-1:0])))
  else $error("pattern write did not land");

  a_sel_ignored:
  assert property (@(posedge clock) disable iff (sys_rst)
    (bus_req && wb_we_i && !wb_sel_i[0]) |=>
      ($stable(st_q.key_match_mask) && $stable(st_q.key_match_pattern)))
  else $error("write without byte lane changed a register");

  a_int_req_off:
  assert property (@(posedge clock) disable iff (sys_rst)
    !st_q.int_en |-> !key_int_req)
  else $error("interrupt request while disabled");

  a_int_req_on:
  assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.pattern_match_flag && st_q.int_en) |-> key_int_req)
  else $error("enabled flag raised no interrupt request");

  a_wake_idle:
  assert property (@(posedge clock) disable iff (sys_rst)
    (idle_mode && st_q.pattern_match_flag && st_q.int_en) |=> core_wake)
  else $error("enabled flag did not wake from idle");

  a_wake_power_down:
  assert property (@(posedge clock) disable iff (sys_rst)
    (power_down_mode && st_q.pattern_match_flag && st_q.int_en) |=> core_wake)
  else $error("enabled flag did not wake from power-down");

  a_wake_needs_sleep:
  assert property (@(posedge clock) disable iff (sys_rst)
    !sleeping |=> !core_wake)
  else $error("wake raised while the core was awake");

  a_flag_sticky:
  assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.pattern_match_flag &&
     !(bus_wr && addr_hi_zero && bus_addr == PPMI_ADDR_CONTROL &&
       !wb_dat_i[PPMI_CTL_FLAG_BIT])) |=> st_q.pattern_match_flag)
  else $error("flag dropped without a clearing write");

  a_flag_sets_again:
  assert property (@(posedge clock) disable iff (sys_rst)
    (bus_wr && addr_hi_zero && bus_addr == PPMI_ADDR_CONTROL &&
     !wb_dat_i[PPMI_CTL_FLAG_BIT] && flag_set) |=> st_q.pattern_match_flag)
  else $error("held match lost the flag on a clear");

endmodule

`default_nettype wire

// *** ppmi_keypad.sv ***
`timescale 1ns/100ps
`default_nettype none
// pull-ups on every line; a pressed key pulls its line low
module ppmi_keypad (
  input  wire logic [7:0] press,
  output logic      [7:0] lines
);
  assign lines = ~press;
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ppmi_pkg::*;
  typedef struct packed {
    logic [7:0] msk, pat, prs;
    logic       pol, ien;
    logic [3:0] n;
    logic       flag;
  } ppmi_row_t;
  logic        clock = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, idl = 0, pd = 0;
  logic [31:0] adr = 0, dat = 0, rdat, q;
  logic [3:0]  sel = 4'h1;
  logic [7:0]  press = 0, lines;
  logic        ack, kreq, wake, irq;
  int          n_fail = 0, samples_checked = 0, cycles = 0;
  ppmi_row_t   rows [6] = '{
    '{8'hff, 8'hff, 8'h01, 1'b1, 1'b1, 4'd7, 1'b1},
    '{8'hff, 8'hff, 8'h01, 1'b1, 1'b1, 4'd6, 1'b0},
    '{8'hfe, 8'hff, 8'h01, 1'b1, 1'b1, 4'd9, 1'b0},
    '{8'h0f, 8'hfa, 8'h05, 1'b0, 1'b0, 4'd8, 1'b1},
    '{8'h0f, 8'hfa, 8'h04, 1'b0, 1'b1, 4'd8, 1'b0},
    '{8'h0f, 8'h00, 8'h0f, 1'b0, 1'b1, 4'd8, 1'b1}};

  ppmi_keypad ppmi_keypad_i (.press(press), .lines(lines));
  ppmi_top ppmi_top_i (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port_in(lines), .idle_mode(idl), .power_down_mode(pd),
    .key_int_req(kreq), .core_wake(wake), .irq(irq));

  initial begin
    forever #50 clock = ~clock;
  end

  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles > 5000) begin
      n_fail++;
      report_and_stop;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // entered right after a rising edge; waits for ack, takes data at that edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {24'h0, a};
    dat <= d;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask

  task automatic arm(input logic [7:0] m, input logic [7:0] p, input logic [2:0] c);
    wb(PPMI_ADDR_CONTROL, 1, 0);
    wb(PPMI_ADDR_MASK, 1, 32'(m));
    wb(PPMI_ADDR_PATTERN, 1, 32'(p));
    wb(PPMI_ADDR_CONTROL, 1, 32'(c));
    wb(PPMI_ADDR_IRQ_STAT, 1, 32'h3);
  endtask

  task automatic hit(input logic [7:0] k, input int n);
    press <= k;
    repeat (n) @(posedge clock);
    press <= 8'h00;
    repeat (4) @(posedge clock);
  endtask

  task automatic flag_is(input logic e);
    wb(PPMI_ADDR_CONTROL, 0, 0);
    chk(32'(q[3]), 32'(e));
  endtask

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    wb(PPMI_ADDR_MASK, 0, 0);
    chk(q, 32'(PPMI_MASK_RST));
    wb(PPMI_ADDR_CONTROL, 0, 0);
    chk(q, 0);
    chk(32'({kreq, wake, irq}), 0);
    wb(8'h20, 0, 0);
    chk(q, 0);
    press <= 8'h3c;
    wb(PPMI_ADDR_PORT, 0, 0);
    chk(q, 32'h000000c3);
    press <= 8'h00;
    $display("test reset done");
    foreach (rows[i]) begin
      arm(rows[i].msk, rows[i].pat, {rows[i].ien, rows[i].pol, 1'b1});
      hit(rows[i].prs, 32'(rows[i].n));
      flag_is(rows[i].flag);
      @(negedge clock);
      chk(32'(kreq), 32'(rows[i].flag & rows[i].ien));
      chk(32'(wake), 0);
      @(posedge clock);
    end
    $display("test rows done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk(32'({kreq, wake, irq}), 0);
    wb(PPMI_ADDR_MASK, 0, 0);
    chk(q, 32'(PPMI_MASK_RST));
    wb(PPMI_ADDR_CONTROL, 0, 0);
    chk(q, 0);
    $display("test mid reset done");
    wb(PPMI_ADDR_MASK, 1, 32'h5a);
    sel <= 4'h0;
    wb(PPMI_ADDR_MASK, 1, 32'ha5);
    sel <= 4'h1;
    wb(PPMI_ADDR_MASK, 0, 0);
    chk(q, 32'h5a);
    $display("test byte lane done");
    arm(8'hff, 8'hff, 3'b110);
    hit(8'h01, 10);
    flag_is(1'b0);
    arm(8'hff, 8'hff, 3'b111);
    wb(PPMI_ADDR_IRQ_MASK, 1, 32'h1);
    hit(8'h01, 7);
    repeat (20) @(posedge clock);
    flag_is(1'b1);
    chk(32'(irq), 1);
    wb(PPMI_ADDR_IRQ_STAT, 1, 32'h1);
    chk(32'(irq), 0);
    wb(PPMI_ADDR_CONTROL, 1, 32'h7);
    flag_is(1'b0);
    press <= 8'h01;
    repeat (12) @(posedge clock);
    wb(PPMI_ADDR_CONTROL, 1, 32'h7);
    repeat (3) @(posedge clock);
    flag_is(1'b1);
    press <= 8'h00;
    $display("test sticky done");
    arm(8'hff, 8'hff, 3'b111);
    wb(PPMI_ADDR_IRQ_MASK, 1, 32'h0);
    hit(8'h01, 8);
    wb(PPMI_ADDR_IRQ_STAT, 0, 0);
    chk(q, 32'h1);
    chk(32'(irq), 0);
    $display("test irq mask done");
    for (int m = 0; m < 2; m++) begin
      arm(8'hff, 8'hff, 3'b111);
      idl <= (m == 0);
      pd  <= (m == 1);
      hit(8'h02, 8);
      @(negedge clock);
      chk(32'(wake), 1);
      @(posedge clock);
      wb(PPMI_ADDR_IRQ_STAT, 0, 0);
      chk(32'(q[1]), 1);
      idl <= 1'b0;
      pd  <= 1'b0;
    end
    $display("test wake done");
    report_and_stop;
  end
endmodule
`default_nettype wire
